// ==== rtl/cbc_pkg.sv ====
package cbc_pkg;
    localparam int          PC_W          = 21;
    localparam logic [3:0]  OP_HI_BRANCH  = 4'he;
    localparam logic [3:0]  OP_BOV        = 4'h4;
    localparam logic [3:0]  OP_BZ         = 4'h0;
    localparam logic [2:0]  OP_CALL_HI    = 3'h6;
    localparam logic [3:0]  OP_CALL_WORD2 = 4'hf;
    localparam logic [20:0] PC_STEP       = 21'h000002;
    localparam logic [20:0] CALL_RET_OFS  = 21'h000004;
    localparam logic [20:0] PC_RST        = 21'h000000;
    localparam logic [1:0]  Q_RST         = 2'h0;

    typedef struct packed {
        logic [7:0] work;
        logic [7:0] flags;
        logic [7:0] bank;
    } cbc_ctx_t;

    typedef struct packed {
        logic        push;
        logic [20:0] data;
    } cbc_push_t;
endpackage

// ==== rtl/cbc_exec.sv ====
`timescale 1ns/10ps
module cbc_exec
    import cbc_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    ce_in,
    // Instruction word and core state
    input  wire logic                    instr_valid_in,
    input  wire logic [15:0]             instr_in,
    input  wire logic                    ovf_flag_in,
    input  wire logic                    zero_flag_in,
    input  wire cbc_pkg::cbc_ctx_t       ctx_in,
    // Results
    output logic      [20:0]             pc_out,
    output logic      [1:0]              qphase_out,
    output logic                         busy_out,
    output logic                         nop_cycle_out,
    output cbc_pkg::cbc_push_t           push_out,
    output cbc_pkg::cbc_ctx_t            shadow_out,
    output logic      [7:0]              flags_out
);
    import cbc_pkg::*;

    typedef enum logic [3:0] {
        CBC_IDLE  = 4'h1,
        CBC_EXEC  = 4'h2,
        CBC_CALL2 = 4'h4,
        CBC_NOP   = 4'h8
    } cbc_state_t;

    typedef enum logic [2:0] {
        CBC_K_NONE = 3'h1,
        CBC_K_BR   = 3'h2,
        CBC_K_CALL = 3'h4
    } cbc_kind_t;

    typedef struct packed {
        cbc_state_t  st;
        cbc_kind_t   kind;
        logic [1:0]  q;
        logic [15:0] ir;
        logic        taken;
        logic        save;
        logic [7:0]  klo;
        logic [20:0] pc;
        logic [20:0] tgt;
        cbc_push_t   push;
        cbc_ctx_t    shadow;
    } cbc_regs_t;

    cbc_regs_t r_ff;
    cbc_regs_t nxt_r;

    function automatic logic [20:0] cbc_rel(input logic [20:0] pc, input logic [7:0] n);
        logic [20:0] ofs;
        ofs = {{12{n[7]}}, n, 1'b0};
        return pc + PC_STEP + ofs;
    endfunction

    function automatic logic is_branch(input logic [15:0] w);
        return w[15:12] == OP_HI_BRANCH && (w[11:8] == OP_BOV || w[11:8] == OP_BZ);
    endfunction

    function automatic logic r_ir_bz();
        return r_ff.ir[11:8] == OP_BZ;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_r = r_ff;
        nxt_r.push.push = 1'b0;
        nxt_r.q = r_ff.q + 2'h1;
        case (r_ff.st)
            CBC_IDLE: begin
                nxt_r.q = Q_RST;
                if (instr_valid_in) begin
                    nxt_r.ir = instr_in;
                    nxt_r.st = CBC_EXEC;
                    if (is_branch(instr_in)) begin
                        nxt_r.kind = CBC_K_BR;
                    end else if (instr_in[15:12] == OP_HI_BRANCH && instr_in[11:9] == OP_CALL_HI) begin
                        nxt_r.kind = CBC_K_CALL;
                    end else begin
                        nxt_r.kind = CBC_K_NONE;
                        nxt_r.pc   = r_ff.pc + PC_STEP;
                        nxt_r.st   = CBC_IDLE;
                    end
                end
            end
            CBC_EXEC: begin
                case (r_ff.q)
                    2'h0: begin
                        nxt_r.save  = r_ff.ir[8];
                        nxt_r.taken = (r_ff.ir[11:8] == OP_BOV) ? ovf_flag_in : zero_flag_in;
                    end
                    2'h1: begin
                        nxt_r.klo = r_ff.ir[7:0];
                    end
                    2'h2: begin
                        if (r_ff.kind == CBC_K_CALL) begin
                            nxt_r.push.push = 1'b1;
                            nxt_r.push.data = r_ff.pc + CALL_RET_OFS;
                            if (r_ff.save) begin
                                nxt_r.shadow = ctx_in;
                            end
                        end else begin
                            nxt_r.tgt = cbc_rel(r_ff.pc, r_ff.klo);
                        end
                    end
                    default: begin
                        if (r_ff.kind == CBC_K_CALL) begin
                            nxt_r.st = CBC_CALL2;
                        end else if (r_ff.taken) begin
                            nxt_r.pc = r_ff.tgt;
                            nxt_r.st = CBC_NOP;
                        end else begin
                            nxt_r.pc = r_ff.pc + PC_STEP;
                            nxt_r.st = CBC_IDLE;
                        end
                    end
                endcase
            end
            CBC_CALL2: begin
                if (instr_valid_in && instr_in[15:12] == OP_CALL_WORD2) begin
                    nxt_r.pc = {instr_in[11:0], r_ff.klo, 1'b0};
                    nxt_r.st = CBC_NOP;
                    nxt_r.q  = Q_RST;
                end else begin
                    nxt_r.q  = Q_RST;
                end
            end
            CBC_NOP: begin
                if (r_ff.q == 2'h3) begin
                    nxt_r.st = CBC_IDLE;
                end
            end
            default: begin
                nxt_r.st = CBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_ff <= '{st: CBC_IDLE, kind: CBC_K_NONE, q: Q_RST, ir: 16'h0000, taken: 1'b0,
                      save: 1'b0, klo: 8'h00, pc: PC_RST, tgt: PC_RST,
                      push: '{push: 1'b0, data: PC_RST},
                      shadow: '{work: 8'h00, flags: 8'h00, bank: 8'h00}};
        end else if (ce_in) begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign pc_out        = r_ff.pc;
    assign qphase_out    = r_ff.q;
    assign busy_out      = r_ff.st != CBC_IDLE;
    assign nop_cycle_out = r_ff.st == CBC_NOP;
    assign push_out      = r_ff.push;
    assign shadow_out    = r_ff.shadow;
    assign flags_out     = ctx_in.flags;

    ////////////////////////////////////////////////////////////////////////
    AST_BR_TAKEN: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && r_ff.st == CBC_EXEC && r_ff.kind == CBC_K_BR && r_ff.q == 2'h3 && r_ff.taken
        |=> pc_out == $past(r_ff.pc) + PC_STEP + {{12{$past(r_ff.ir[7])}}, $past(r_ff.ir[7:0]), 1'b0})
        else $error("taken branch target wrong");
    AST_BR_FALL: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && r_ff.st == CBC_EXEC && r_ff.kind == CBC_K_BR && r_ff.q == 2'h3 && !r_ff.taken
        |=> pc_out == $past(r_ff.pc) + PC_STEP && !busy_out)
        else $error("untaken branch pc wrong");
    AST_BR_DECODE: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && !busy_out && instr_valid_in && is_branch(instr_in) |=> r_ff.kind == CBC_K_BR)
        else $error("branch opcode not decoded");
    AST_BR_COND: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && r_ff.st == CBC_EXEC && r_ff.kind == CBC_K_BR && r_ff.q == 2'h0 && r_ir_bz()
        |=> r_ff.taken == $past(zero_flag_in))
        else $error("zero branch condition wrong");
    AST_NOP_LEN: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && r_ff.st == CBC_EXEC && r_ff.q == 2'h3 && r_ff.taken && r_ff.kind == CBC_K_BR
        ##1 ce_in [*4] |=> !busy_out)
        else $error("nop cycle length wrong");
    AST_PC_Q4: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && r_ff.st == CBC_EXEC && r_ff.q != 2'h3 |=> $stable(pc_out))
        else $error("pc written outside Q4");
    AST_PUSH: assert property (@(posedge clk_in) disable iff (rst_in)
        push_out.push |-> push_out.data == r_ff.pc + CALL_RET_OFS)
        else $error("pushed return address wrong");
    AST_CALL_PC: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && r_ff.st == CBC_CALL2 && instr_valid_in && instr_in[15:12] == OP_CALL_WORD2
        |=> pc_out == {$past(instr_in[11:0]), $past(r_ff.klo), 1'b0} && pc_out[0] == 1'b0)
        else $error("call target wrong");
    AST_NO_SAVE: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && r_ff.kind == CBC_K_CALL && !r_ff.save && r_ff.st == CBC_EXEC |=> $stable(shadow_out))
        else $error("shadow changed without save");
    AST_SAVE: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(push_out.push) && r_ff.save |-> shadow_out == $past(ctx_in))
        else $error("shadow save missing");

    COV_TAKEN: cover property (@(posedge clk_in) disable iff (rst_in) r_ff.st == CBC_NOP && r_ff.kind == CBC_K_BR);
    COV_UNTAKEN: cover property (@(posedge clk_in) disable iff (rst_in)
        r_ff.st == CBC_EXEC && r_ff.q == 2'h3 && !r_ff.taken && r_ff.kind == CBC_K_BR);
    COV_CALL_SAVE: cover property (@(posedge clk_in) disable iff (rst_in) push_out.push && r_ff.save);
endmodule

// ==== dv/cbc_exec_bench.sv ====
`timescale 1ns/10ps
module cbc_exec_bench;
    import cbc_pkg::*;
    logic        clk_in         = 1'b0;
    logic        rst_in         = 1'b1;
    logic        ce_in          = 1'b1;
    logic        instr_valid_in = 1'b0;
    logic [15:0] instr_in       = 16'h0000;
    logic        ovf_flag_in    = 1'b0;
    logic        zero_flag_in   = 1'b0;
    cbc_ctx_t    ctx_in         = '0;
    logic [20:0] pc_out;
    logic [1:0]  qphase_out;
    logic        busy_out;
    logic        nop_cycle_out;
    cbc_push_t   push_out;
    cbc_ctx_t    shadow_out;
    logic [7:0]  flags_out;
    logic [20:0] exp_pc;
    int          err_count      = 0;
    int          cmp_count      = 0;

    always #12.5 clk_in = ~clk_in;

    cbc_exec dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .ovf_flag_in(ovf_flag_in), .zero_flag_in(zero_flag_in), .ctx_in(ctx_in),
        .pc_out(pc_out), .qphase_out(qphase_out), .busy_out(busy_out), .nop_cycle_out(nop_cycle_out),
        .push_out(push_out), .shadow_out(shadow_out), .flags_out(flags_out));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Target of a taken branch: base past the branch plus doubled signed offset
    function automatic logic [20:0] br_target(input logic [20:0] pc, input logic [7:0] n);
        return pc + PC_STEP + {{12{n[7]}}, n, 1'b0};
    endfunction

    // Called at a falling edge with the block idle; the other flag is set opposite
    task automatic do_branch(input logic [3:0] sel, input logic [7:0] n, input logic flag);
        logic [20:0] start;
        int          bn;
        int          nn;
        start = exp_pc;
        bn = 0;
        nn = 0;
        instr_in = {OP_HI_BRANCH, sel, n};
        instr_valid_in = 1'b1;
        ovf_flag_in = (sel == OP_BOV) ? flag : ~flag;
        zero_flag_in = (sel == OP_BZ) ? flag : ~flag;
        @(posedge clk_in);
        @(negedge clk_in);
        instr_valid_in = 1'b0;
        while (busy_out === 1'b1 && bn < 20) begin
            bn++;
            nn += (nop_cycle_out === 1'b1) ? 1 : 0;
            if (bn == 4) check("pc_before_q4", 24'(start), 24'(pc_out));
            if (bn == 4) check("qphase_q4", 24'd3, 24'(qphase_out));
            @(negedge clk_in);
        end
        exp_pc = flag ? br_target(start, n) : start + PC_STEP;
        check("branch_pc", 24'(exp_pc), 24'(pc_out));
        check("branch_busy", flag ? 24'd8 : 24'd4, 24'(bn));
        check("branch_nop", flag ? 24'd4 : 24'd0, 24'(nn));
        check("flags", 24'(ctx_in.flags), 24'(flags_out));
    endtask

    // Word 1, then a word not starting 1111 that must be ignored, then word 2
    task automatic do_call(input logic [19:0] k, input logic s);
        cbc_ctx_t    ctx;
        cbc_ctx_t    old_sh;
        logic [20:0] start;
        int          i;
        start = exp_pc;
        old_sh = shadow_out;
        ctx = cbc_ctx_t'(24'($urandom));
        ctx_in = ctx;
        instr_in = {OP_HI_BRANCH, OP_CALL_HI, s, k[7:0]};
        instr_valid_in = 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        instr_in = 16'h1234;
        repeat (3) @(negedge clk_in);
        check("push", {2'b00, 1'b1, start + CALL_RET_OFS}, 24'(push_out));
        @(negedge clk_in);
        check("push_pulse", 24'd0, 24'(push_out.push));
        repeat (2) @(negedge clk_in);
        check("word2_wait", 24'd0, 24'(nop_cycle_out));
        instr_in = {OP_CALL_WORD2, k[19:8]};
        i = 0;
        while (nop_cycle_out !== 1'b1 && i < 10) begin
            @(negedge clk_in);
            i++;
        end
        instr_valid_in = 1'b0;
        exp_pc = {k, 1'b0};
        check("call_pc", 24'(exp_pc), 24'(pc_out));
        check("shadow", s ? ctx : old_sh, shadow_out);
        i = 0;
        while (nop_cycle_out === 1'b1 && i < 20) begin
            i++;
            @(negedge clk_in);
        end
        check("call_nop", 24'd4, 24'(i));
        check("call_idle", 24'd0, 24'(busy_out));
        check("flags", 24'(ctx_in.flags), 24'(flags_out));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        void'($urandom(23));
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        exp_pc = PC_RST;
        check("pc_reset", 24'(PC_RST), 24'(pc_out));
        do_branch(OP_BOV, 8'h7f, 1'b1);
        do_branch(OP_BOV, 8'h80, 1'b1);
        do_branch(OP_BZ, 8'h80, 1'b1);
        do_branch(OP_BZ, 8'h7f, 1'b0);
        do_branch(OP_BOV, 8'h00, 1'b0);
        do_call(20'hfffff, 1'b1);
        do_call(20'h00001, 1'b0);
        for (i = 0; i < 40; i++) begin
            if ($urandom_range(2) == 0) do_call(20'($urandom), 1'($urandom));
            else do_branch($urandom_range(1) ? OP_BOV : OP_BZ, 8'($urandom), 1'($urandom));
        end
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        complete_run();
    end
endmodule
